// ---- verilog/frs_fault_status.sv ----
// fault response, latched-off control and summary status for one channel
`timescale 1ns/1ps
`default_nettype none
module frs_fault_status (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // command port
   input wire logic cmd_valid,
   input wire logic cmd_read,
   input wire logic [7:0] cmd_code,
   input wire logic [7:0] cmd_wdata,
   input wire logic bus_busy,
   output logic rsp_valid,
   output logic [15:0] rsp_data,
   // channel pins and configuration
   input wire logic control_pin,
   input wire logic input_sense_pin,
   input wire logic delayed_off_mode,
   input wire logic [15:0] toff_delay,
   input wire logic [2:0] global_retry_count,
   input wire logic power_good_enable,
   input wire logic power_good_out,
   // fault and warning events
   input wire logic ton_timeout,
   input wire logic other_fault_off,
   input wire logic vout_event,
   input wire logic output_overvoltage_flag,
   input wire logic input_event,
   input wire logic input_undervoltage_flag,
   input wire logic mfr_event,
   input wire logic temp_event,
   input wire logic cml_event,
   // outputs
   output logic channel_enable,
   output logic alert_n
);
   ////////////////////////////////////////////////////////////////////////////
   frs_pkg::frs_state_t state;
   frs_pkg::frs_state_t next_state;
   logic [7:0] ton_response;
   logic [7:0] oper;
   logic [2:0] retries_left;
   logic [15:0] off_count;
   logic control_q;
   logic bias_q;
   logic [15:0] sticky;
   logic [15:0] word;
   logic wr;
   logic rd;
   logic clear_cmd;
   logic run_cmd;
   logic enabled;
   logic release_evt;
   logic bias_lost;
   logic act_nonzero;
   logic retry_nonzero;
   logic shut_now;
   logic can_retry;
   logic user_on;
   logic pnot_good;

   assign wr = cmd_valid & ~cmd_read;
   assign rd = cmd_valid & cmd_read;
   assign clear_cmd = wr & (cmd_code == frs_pkg::CMD_CLEAR_FAULTS);
   assign run_cmd = wr & ((cmd_code == frs_pkg::CMD_OPERATION)
      | (cmd_code == frs_pkg::CMD_ON_OFF_CONFIG));
   assign enabled = control_pin & oper[frs_pkg::OPER_ON_BIT] & input_sense_pin;
   assign bias_lost = bias_q & ~input_sense_pin;
   assign release_evt = (control_pin != control_q) | run_cmd | bias_lost;
   assign act_nonzero = |ton_response[frs_pkg::RESP_ACTION_HI:frs_pkg::RESP_ACTION_LO];
   assign retry_nonzero = |ton_response[frs_pkg::RESP_RETRY_HI:frs_pkg::RESP_RETRY_LO];
   assign can_retry = retry_nonzero & (retries_left != 3'h0);
   assign shut_now = ton_timeout & act_nonzero & ~delayed_off_mode;
   assign user_on = (state == frs_pkg::FRS_OFF) & enabled;

   ////////////////////////////////////////////////////////////////////////////
   // registers written by commands
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ton_response <= frs_pkg::RESP_RESET;
         oper <= frs_pkg::OPER_RESET;
      end
      else
      begin
         if (wr && cmd_code == frs_pkg::CMD_TON_RESPONSE)
         begin
            ton_response <= cmd_wdata & frs_pkg::RESP_WRITE_MASK;
         end
         if (wr && cmd_code == frs_pkg::CMD_OPERATION)
         begin
            oper <= cmd_wdata;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         control_q <= 1'b0;
         bias_q <= 1'b0;
      end
      else
      begin
         control_q <= control_pin;
         bias_q <= input_sense_pin;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // channel state machine
   always_comb
   begin
      next_state = state;
      case (state)
         frs_pkg::FRS_OFF:
         begin
            if (enabled)
            begin
               next_state = frs_pkg::FRS_ON;
            end
         end
         frs_pkg::FRS_ON:
         begin
            if (!enabled)
            begin
               next_state = frs_pkg::FRS_OFF;
            end
            else if (other_fault_off)
            begin
               next_state = frs_pkg::FRS_LATCHED;
            end
            else if (ton_timeout && act_nonzero && delayed_off_mode)
            begin
               next_state = frs_pkg::FRS_DELAY;
            end
            else if (shut_now)
            begin
               next_state = can_retry ? frs_pkg::FRS_RETRY : frs_pkg::FRS_LATCHED;
            end
         end
         frs_pkg::FRS_DELAY:
         begin
            if (!enabled)
            begin
               next_state = frs_pkg::FRS_OFF;
            end
            else if (other_fault_off)
            begin
               next_state = frs_pkg::FRS_LATCHED;
            end
            else if (off_count == 16'h0000)
            begin
               next_state = can_retry ? frs_pkg::FRS_RETRY : frs_pkg::FRS_LATCHED;
            end
         end
         frs_pkg::FRS_RETRY:
         begin
            next_state = enabled ? frs_pkg::FRS_ON : frs_pkg::FRS_OFF;
         end
         frs_pkg::FRS_LATCHED:
         begin
            if (release_evt)
            begin
               next_state = frs_pkg::FRS_OFF;
            end
         end
         default:
         begin
            next_state = frs_pkg::FRS_OFF;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= frs_pkg::FRS_OFF;
      end
      else
      begin
         state <= next_state;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         off_count <= 16'h0000;
      end
      else if (state != frs_pkg::FRS_DELAY)
      begin
         off_count <= toff_delay;
      end
      else if (off_count != 16'h0000)
      begin
         off_count <= off_count - 16'h0001;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         retries_left <= 3'h0;
      end
      else if (user_on)
      begin
         retries_left <= global_retry_count;
      end
      else if (next_state == frs_pkg::FRS_RETRY && state != frs_pkg::FRS_RETRY)
      begin
         retries_left <= retries_left - 3'h1;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         channel_enable <= 1'b0;
      end
      else
      begin
         channel_enable <= (next_state == frs_pkg::FRS_ON)
            | (next_state == frs_pkg::FRS_DELAY);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sticky summary bits, set wins over clear
   logic [15:0] set_vec;
   always_comb
   begin
      set_vec = 16'h0000;
      set_vec[frs_pkg::SW_VOUT] = vout_event | output_overvoltage_flag | ton_timeout;
      set_vec[frs_pkg::SW_INPUT] = input_event | input_undervoltage_flag;
      set_vec[frs_pkg::SW_MFR] = mfr_event;
      set_vec[frs_pkg::SW_BUSY] = cmd_valid & bus_busy;
      set_vec[frs_pkg::SW_VOUT_OV] = output_overvoltage_flag;
      set_vec[frs_pkg::SW_VIN_UV] = input_undervoltage_flag;
      set_vec[frs_pkg::SW_TEMP] = temp_event;
      set_vec[frs_pkg::SW_CML] = cml_event;
      set_vec[frs_pkg::SW_HIGH] = ton_timeout | vout_event | input_event | mfr_event;
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sticky <= 16'h0000;
      end
      else
      begin
         sticky <= set_vec | ((clear_cmd | user_on) ? 16'h0000 : sticky);
      end
   end

   assign pnot_good = power_good_enable & ~power_good_out;
   always_comb
   begin
      word = sticky;
      word[frs_pkg::SW_PNG] = pnot_good;
      word[frs_pkg::SW_OFF] = ~channel_enable;
      word[frs_pkg::SW_HIGH] = sticky[frs_pkg::SW_HIGH] | pnot_good;
   end
   assign alert_n = ~(|sticky);

   ////////////////////////////////////////////////////////////////////////////
   // read answers
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rsp_valid <= 1'b0;
         rsp_data <= 16'h0000;
      end
      else
      begin
         rsp_valid <= rd;
         if (rd)
         begin
            case (cmd_code)
               frs_pkg::CMD_STATUS_BYTE: rsp_data <= {8'h00, word[7:0]};
               frs_pkg::CMD_STATUS_WORD: rsp_data <= word;
               frs_pkg::CMD_TON_RESPONSE: rsp_data <= {8'h00, ton_response};
               frs_pkg::CMD_OPERATION: rsp_data <= {8'h00, oper};
               default: rsp_data <= 16'h0000;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_timeout_latch;
      state == frs_pkg::FRS_ON && enabled && !other_fault_off && shut_now && !can_retry;
   endsequence
   sequence s_latched_off;
      state == frs_pkg::FRS_LATCHED ##1 !channel_enable;
   endsequence

   chk_action_zero_runs: assert property (@(posedge clock) disable iff (!rst_n)
      state == frs_pkg::FRS_ON && enabled && ton_timeout && !act_nonzero && !other_fault_off
      |=> state == frs_pkg::FRS_ON && channel_enable)
      else $error("channel stopped on timeout with action zero");
   chk_timeout_latches: assert property (@(posedge clock) disable iff (!rst_n)
      s_timeout_latch |=> s_latched_off)
      else $error("timeout without retry did not latch off");
   chk_delay_counts: assert property (@(posedge clock) disable iff (!rst_n)
      state == frs_pkg::FRS_DELAY && off_count != 16'h0000 && enabled && !other_fault_off
      |=> state == frs_pkg::FRS_DELAY && channel_enable)
      else $error("delayed turn-off ended early");
   chk_retry_restart: assert property (@(posedge clock) disable iff (!rst_n)
      state == frs_pkg::FRS_RETRY && enabled |=> state == frs_pkg::FRS_ON && channel_enable)
      else $error("retry did not restart channel");
   chk_latch_holds: assert property (@(posedge clock) disable iff (!rst_n)
      state == frs_pkg::FRS_LATCHED && !release_evt |=> state == frs_pkg::FRS_LATCHED)
      else $error("latched fault released without cause");
   chk_delay_reads_zero: assert property (@(posedge clock) disable iff (!rst_n)
      ton_response[2:0] == 3'h0)
      else $error("response delay field not zero");
   chk_byte_matches_word: assert property (@(posedge clock) disable iff (!rst_n)
      rd && cmd_code == frs_pkg::CMD_STATUS_BYTE |=> rsp_valid && rsp_data == {8'h00, $past(word[7:0])})
      else $error("byte summary differs from word low byte");
   chk_timeout_flags: assert property (@(posedge clock) disable iff (!rst_n)
      ton_timeout |=> sticky[frs_pkg::SW_VOUT] && sticky[frs_pkg::SW_HIGH] && !alert_n)
      else $error("timeout did not set summary and alert");
   chk_clear_status: assert property (@(posedge clock) disable iff (!rst_n)
      clear_cmd && set_vec == 16'h0000 |=> sticky == 16'h0000 && alert_n)
      else $error("clear command left status set");
   chk_unsupported_zero: assert property (@(posedge clock) disable iff (!rst_n)
      word[14] == 1'b0 && word[10:8] == 3'h0 && word[4] == 1'b0)
      else $error("unsupported summary bit set");
   chk_off_tracks: assert property (@(posedge clock) disable iff (!rst_n)
      word[frs_pkg::SW_OFF] == !(state == frs_pkg::FRS_ON || state == frs_pkg::FRS_DELAY)
      && word[frs_pkg::SW_PNG] == (power_good_enable && !power_good_out))
      else $error("live summary bits wrong");
endmodule // frs_fault_status
`default_nettype wire

// ---- verilog/frs_pkg.sv ----
// constants and types for the fault response and status summary block
package frs_pkg;
   // command codes (management bus command numbers)
   localparam logic [7:0] CMD_OPERATION = 8'h01;
   localparam logic [7:0] CMD_ON_OFF_CONFIG = 8'h02;
   localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
   localparam logic [7:0] CMD_TON_RESPONSE = 8'h63;
   localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
   localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
   // start-up timeout response fields
   localparam int RESP_ACTION_HI = 7;
   localparam int RESP_ACTION_LO = 6;
   localparam int RESP_RETRY_HI = 5;
   localparam int RESP_RETRY_LO = 3;
   localparam logic [7:0] RESP_WRITE_MASK = 8'hf8;
   localparam logic [7:0] RESP_RESET = 8'h80;
   // operation register on bit
   localparam int OPER_ON_BIT = 7;
   localparam logic [7:0] OPER_RESET = 8'h00;
   // summary word bit positions
   localparam int SW_VOUT = 15;
   localparam int SW_INPUT = 13;
   localparam int SW_MFR = 12;
   localparam int SW_PNG = 11;
   localparam int SW_BUSY = 7;
   localparam int SW_OFF = 6;
   localparam int SW_VOUT_OV = 5;
   localparam int SW_VIN_UV = 3;
   localparam int SW_TEMP = 2;
   localparam int SW_CML = 1;
   localparam int SW_HIGH = 0;
   // channel states
   typedef enum logic [2:0] {
      FRS_OFF = 3'b000,
      FRS_ON = 3'b001,
      FRS_DELAY = 3'b010,
      FRS_RETRY = 3'b011,
      FRS_LATCHED = 3'b100
   } frs_state_t;
endpackage

// ---- dv/frs_host.sv ----
// host controller model issuing commands on the block's command port
`timescale 1ns/1ps
`default_nettype none
module frs_host (
   // clock
   input wire logic clock,
   // command port
   output logic cmd_valid,
   output logic cmd_read,
   output logic [7:0] cmd_code,
   output logic [7:0] cmd_wdata,
   input wire logic rsp_valid,
   input wire logic [15:0] rsp_data
);
   initial
   begin
      cmd_valid = 1'b0;
      cmd_read = 1'b0;
      cmd_code = 8'h00;
      cmd_wdata = 8'h00;
   end
   ////////////////////////////////////////////////////////////////////////////
   // one command, strobe high across exactly one rising edge
   task automatic send(input logic rd, input logic [7:0] code, input logic [7:0] data);
      @(negedge clock);
      cmd_valid = 1'b1;
      cmd_read = rd;
      cmd_code = code;
      cmd_wdata = data;
      @(negedge clock);
      cmd_valid = 1'b0;
      cmd_code = ~code;
      cmd_wdata = ~data;
   endtask
   // read, then wait a bounded time for the answer
   task automatic read(input logic [7:0] code, output logic [15:0] data);
      int n;
      send(1'b1, code, 8'h00);
      n = 0;
      while (rsp_valid !== 1'b1 && n < 4)
      begin
         @(negedge clock);
         n++;
      end
      data = (rsp_valid === 1'b1) ? rsp_data : 16'hxxxx;
   endtask
endmodule // frs_host
`default_nettype wire

// ---- dv/fault_response_status_summary_test.sv ----
// self-checking testbench for the fault response and status summary block
`timescale 1ns/1ps
`default_nettype none
module fault_response_status_summary_test;
   logic clock, rst_n, bus_busy, cmd_valid, cmd_read, rsp_valid, control_pin, input_sense_pin;
   logic delayed_off_mode, power_good_enable, power_good_out, channel_enable, alert_n;
   logic [7:0] cmd_code, cmd_wdata;
   logic [15:0] rsp_data, toff_delay;
   logic [2:0] global_retry_count;
   logic [8:0] ev;
   int mismatches, checked;
   int pos[7] = '{15, 5, 13, 3, 12, 2, 1};
   ////////////////////////////////////////////////////////////////////////////
   frs_host i_host (.clock(clock), .cmd_valid(cmd_valid), .cmd_read(cmd_read),
      .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
   frs_fault_status i_dut (.clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid),
      .cmd_read(cmd_read), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .bus_busy(bus_busy),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .control_pin(control_pin),
      .input_sense_pin(input_sense_pin), .delayed_off_mode(delayed_off_mode),
      .toff_delay(toff_delay), .global_retry_count(global_retry_count),
      .power_good_enable(power_good_enable), .power_good_out(power_good_out),
      .ton_timeout(ev[0]), .other_fault_off(ev[1]), .vout_event(ev[2]),
      .output_overvoltage_flag(ev[3]), .input_event(ev[4]), .input_undervoltage_flag(ev[5]),
      .mfr_event(ev[6]), .temp_event(ev[7]), .cml_event(ev[8]),
      .channel_enable(channel_enable), .alert_n(alert_n));
   always #5 clock = ~clock;
   ////////////////////////////////////////////////////////////////////////////
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk_word(input logic [7:0] code, input logic [15:0] mask, input logic [15:0] exp);
      logic [15:0] d;
      i_host.read(code, d);
      checked++;
      if ((d & mask) !== exp)
      begin
         mismatches++;
         $display("MISMATCH %0t code %h got %h exp %h", $time, code, d & mask, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH %0t pin got %b exp %b", $time, got, exp);
      end
   endtask
   task automatic pulse(input int idx);
      @(negedge clock);
      ev[idx] = 1'b1;
      @(negedge clock);
      ev[idx] = 1'b0;
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic wr(input logic [7:0] code, input logic [7:0] data);
      i_host.send(1'b0, code, data);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      #200us;
      mismatches++;
      finish_test();
   end
   initial
   begin
      clock = 1'b0;
      rst_n = 1'b0;
      bus_busy = 1'b0;
      ev = '0;
      control_pin = 1'b1;
      input_sense_pin = 1'b1;
      delayed_off_mode = 1'b0;
      toff_delay = 16'h0003;
      global_retry_count = 3'h0;
      power_good_enable = 1'b0;
      power_good_out = 1'b1;
      mismatches = 0;
      checked = 0;
      wait_n(16);
      rst_n = 1'b1;
      // reset values and read-only zero bits
      chk_word(frs_pkg::CMD_TON_RESPONSE, 16'hffff, 16'h0080);
      chk_word(frs_pkg::CMD_STATUS_WORD, 16'hffff, 16'h0040);
      chk_word(frs_pkg::CMD_STATUS_BYTE, 16'hffff, 16'h0040);
      wr(frs_pkg::CMD_TON_RESPONSE, 8'hff);
      chk_word(frs_pkg::CMD_TON_RESPONSE, 16'hffff, 16'h00f8);
      $display("test reset done");
      // action zero keeps running but records the fault
      wr(frs_pkg::CMD_TON_RESPONSE, 8'h00);
      wr(frs_pkg::CMD_OPERATION, 8'h80);
      wait_n(3);
      chk_word(frs_pkg::CMD_STATUS_WORD, 16'h0040, 16'h0000);
      pulse(0);
      chk_bit(channel_enable, 1'b1);
      chk_bit(alert_n, 1'b0);
      chk_word(frs_pkg::CMD_STATUS_WORD, 16'h8001, 16'h8001);
      wr(frs_pkg::CMD_CLEAR_FAULTS, 8'h00);
      chk_bit(alert_n, 1'b1);
      chk_word(frs_pkg::CMD_STATUS_WORD, 16'hffff, 16'h0000);
      $display("test action zero done");
      // immediate off, no retry, latched through clear
      wr(frs_pkg::CMD_TON_RESPONSE, 8'h80);
      pulse(0);
      chk_bit(channel_enable, 1'b0);
      wait_n(5);
      chk_bit(channel_enable, 1'b0);
      wr(frs_pkg::CMD_CLEAR_FAULTS, 8'h00);
      wait_n(3);
      chk_bit(channel_enable, 1'b0);
      chk_word(frs_pkg::CMD_STATUS_WORD, 16'hffff, 16'h0040);
      wr(frs_pkg::CMD_OPERATION, 8'h80);
      chk_word(frs_pkg::CMD_OPERATION, 16'hffff, 16'h0080);
      wait_n(3);
      chk_bit(channel_enable, 1'b1);
      $display("test latch done");
      // one retry, then latch; control pin toggle releases
      global_retry_count = 3'h1;
      wr(frs_pkg::CMD_TON_RESPONSE, 8'h88);
      control_pin = 1'b0;
      wait_n(3);
      control_pin = 1'b1;
      wait_n(3);
      pulse(0);
      chk_bit(channel_enable, 1'b0);
      wait_n(1);
      chk_bit(channel_enable, 1'b1);
      pulse(0);
      wait_n(4);
      chk_bit(channel_enable, 1'b0);
      control_pin = 1'b0;
      wait_n(3);
      control_pin = 1'b1;
      wait_n(3);
      chk_bit(channel_enable, 1'b1);
      pulse(1);
      wait_n(4);
      chk_bit(channel_enable, 1'b0);
      $display("test retry done");
      // bias loss releases; delayed turn-off
      input_sense_pin = 1'b0;
      wait_n(3);
      input_sense_pin = 1'b1;
      wait_n(3);
      chk_bit(channel_enable, 1'b1);
      delayed_off_mode = 1'b1;
      wr(frs_pkg::CMD_TON_RESPONSE, 8'h80);
      pulse(0);
      chk_bit(channel_enable, 1'b1);
      wait_n(8);
      chk_bit(channel_enable, 1'b0);
      wr(frs_pkg::CMD_ON_OFF_CONFIG, 8'h00);
      wait_n(3);
      chk_bit(channel_enable, 1'b1);
      $display("test delayed off done");
      // each event category sets its summary bit
      wr(frs_pkg::CMD_CLEAR_FAULTS, 8'h00);
      for (int i = 0; i < 7; i++)
      begin
         pulse(i + 2);
         chk_bit(alert_n, 1'b0);
         chk_word(frs_pkg::CMD_STATUS_WORD, 16'h0001 << pos[i], 16'h0001 << pos[i]);
      end
      chk_word(frs_pkg::CMD_STATUS_WORD, 16'h4711, 16'h0001);
      chk_word(frs_pkg::CMD_STATUS_BYTE, 16'hffff, 16'h002f);
      $display("test events done");
      // busy bit, then live power-not-good
      bus_busy = 1'b1;
      wr(frs_pkg::CMD_CLEAR_FAULTS, 8'h00);
      bus_busy = 1'b0;
      chk_word(frs_pkg::CMD_STATUS_WORD, 16'h0081, 16'h0080);
      power_good_enable = 1'b1;
      power_good_out = 1'b0;
      wait_n(1);
      chk_word(frs_pkg::CMD_STATUS_WORD, 16'h0801, 16'h0801);
      power_good_out = 1'b1;
      wr(frs_pkg::CMD_CLEAR_FAULTS, 8'h00);
      chk_word(frs_pkg::CMD_STATUS_WORD, 16'h0801, 16'h0000);
      $display("test busy and power good done");
      finish_test();
   end
endmodule // fault_response_status_summary_test
`default_nettype wire
